// >>> logic/pcig_pkg.sv
`default_nettype none
package pcig_pkg;
  // Register offsets (byte addresses in the register channel)
  localparam logic [11:0] CFG_ADDR_OFF = 12'h500;
  localparam logic [11:0] CFG_DATA_OFF = 12'h504;
  localparam logic [11:0] RETURNED_VECTOR_OFF = 12'h508;
  // Reset values
  localparam logic [31:0] CFG_ADDR_RST = 32'h00000000;
  localparam logic [31:0] CFG_DATA_RST = 32'h00000000;
  localparam logic [31:0] RETURNED_VECTOR_RST = 32'h00000000;
  // Writable bits of the configuration address register (bits 31..24, 15 and 1 hard zero)
  localparam logic [31:0] CFG_ADDR_WMASK = 32'h00FF7FFD;
  // Field positions inside the configuration address register
  localparam int CA_TYPE_BIT = 0;
  localparam int CA_REG_LSB = 2;
  localparam int CA_FUNC_LSB = 8;
  localparam int CA_DEV_LSB = 11;
  // PCI command codes driven on C/BE during the address phase
  localparam logic [3:0] PCI_CMD_IACK = 4'h0;
  localparam logic [3:0] PCI_CMD_CFG_RD = 4'hA;
  localparam logic [3:0] PCI_CMD_CFG_WR = 4'hB;

  // Local bus request as seen by the register channel
  typedef struct packed {
    logic [11:0] addr;   // Register offset
    logic [1:0] lsb;     // Address bits A[1:0]
    logic [1:0] size;    // Transfer size SIZ[1:0]
    logic write;         // 1 = write
    logic [31:0] wdata;  // Write data, no byte swap
  } pcig_req_s;

  // Request toward the PCI master engine
  typedef struct packed {
    logic [3:0] cmd;     // PCI command
    logic [31:0] addr;   // Address phase AD value
    logic [3:0] be_n;    // Byte enables, active low
    logic [31:0] wdata;  // Data phase value for writes
  } pcig_pci_s;

  // Transaction engine states, Gray from IDLE through RUN to DONE
  typedef enum logic [1:0] {
    PCIG_IDLE = 2'b00,
    PCIG_RUN = 2'b01,
    PCIG_DONE = 2'b11
  } pcig_state_e;
endpackage
`default_nettype wire

// >>> logic/pcig_regchan.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Type 1 address phase carries whole address register
// - Type 0 drives one-hot device select AD31..16
// - Type 0 low lines: zero, function, register, zero
// - Address register bit 15 reads zero
// - Local write of data register starts config write
// - Local read of data register starts config read
// - Config accesses retried until PCI cycle completes
// - PCI side data register: writes ignored, reads zero
// - No byte swapping in the register channel
// - Data register access errors without master enable
// - Vector register access errors without master enable
// - Local read of vector register starts IACK
// - IACK byte lanes from SIZ and A bits
// - IACK passes local address onto PCI
// - Retry until vector latched, return on reread
// - Vector writes ignored, PCI reads return zero
module pcig_regchan (
  input wire logic clk,                        // 100 MHz clock
  input wire logic rstn,                       // Async reset, active low
  input wire logic lb_valid,                   // Local bus access strobe
  input wire pcig_pkg::pcig_req_s lb_req,      // Local bus access
  output logic lb_ack,                         // Access completed, data valid
  output logic lb_retry,                       // Access must be repeated
  output logic lb_berr,                        // Access ended with bus error
  output logic [31:0] lb_rdata,                // Read data
  input wire logic pb_valid,                   // PCI side register access
  input wire logic [11:0] pb_addr,             // PCI side offset
  input wire logic pb_write,                   // PCI side write
  input wire logic [31:0] pb_wdata,            // PCI side write data
  output logic pb_ack,                         // PCI side access done
  output logic [31:0] pb_rdata,                // PCI side read data
  input wire logic pci_master_enable,          // Bus master enable, same clock
  output logic pci_req,                        // Start a PCI cycle (level)
  output pcig_pkg::pcig_pci_s pci_cyc,         // Cycle description
  input wire logic pci_done,                   // PCI cycle finished, pulse
  input wire logic [31:0] pci_rdata            // Data from PCI target
);
  ////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] addr_reg, addr_next;            // Configuration address
  logic [31:0] data_reg, data_next;            // Last config payload
  logic [31:0] vec_reg, vec_next;              // Returned vector
  pcig_pkg::pcig_state_e st_reg, st_next;      // Delayed transfer state
  logic [11:0] pend_off_reg, pend_off_next;    // Offset of the pending access
  logic pend_wr_reg, pend_wr_next;             // Pending access is a write
  logic [31:0] pend_wdat_reg, pend_wdat_next;  // Held write data
  logic req_reg, req_next;                     // Cycle request level
  pcig_pkg::pcig_pci_s cyc_reg, cyc_next;      // Cycle description
  logic ack_reg, ack_next, retry_reg, retry_next, berr_reg, berr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic pack_reg, pack_next;
  logic [31:0] prd_reg, prd_next;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Byte lanes from size and low address bits, little-endian lane order
  function automatic logic [3:0] lanes_n(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] en;
    en = 4'h0;
    case (sz)
      2'b01: en = 4'h1 << a;                                  // Byte
      2'b10: en = a[1] ? 4'hC : 4'h3;                         // Half word
      default: en = 4'hF;                                      // Word (00) or 3-byte
    endcase
    lanes_n = ~en;
  endfunction

  // Address phase value for a configuration cycle
  function automatic logic [31:0] cfg_ad(input logic [31:0] ca);
    logic [31:0] ad;
    ad = 32'h00000000;
    if (ca[pcig_pkg::CA_TYPE_BIT]) begin
      ad = ca;
    end else begin
      ad[31:16] = 16'h0001 << ca[pcig_pkg::CA_DEV_LSB +: 4];
      ad[15:11] = 5'h00;
      ad[10:8] = ca[pcig_pkg::CA_FUNC_LSB +: 3];
      ad[7:2] = ca[pcig_pkg::CA_REG_LSB +: 6];
      ad[1:0] = 2'h0;
    end
    cfg_ad = ad;
  endfunction

  // Local offset decode
  logic hit_data, hit_vec, hit_addr;
  assign hit_addr = (lb_req.addr == pcig_pkg::CFG_ADDR_OFF);
  assign hit_data = (lb_req.addr == pcig_pkg::CFG_DATA_OFF);
  assign hit_vec = (lb_req.addr == pcig_pkg::RETURNED_VECTOR_OFF);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for the local channel and delayed transfers
  always_comb begin
    addr_next = addr_reg;
    data_next = data_reg;
    vec_next = vec_reg;
    st_next = st_reg;
    pend_off_next = pend_off_reg;
    pend_wr_next = pend_wr_reg;
    pend_wdat_next = pend_wdat_reg;
    req_next = req_reg;
    cyc_next = cyc_reg;
    ack_next = 1'b0;
    retry_next = 1'b0;
    berr_next = 1'b0;
    rdata_next = rdata_reg;
    // PCI cycle completion latches result
    if (st_reg == pcig_pkg::PCIG_RUN && pci_done) begin
      st_next = pcig_pkg::PCIG_DONE;
      req_next = 1'b0;
      if (pend_off_reg == pcig_pkg::RETURNED_VECTOR_OFF) begin
        vec_next = pci_rdata;
      end else if (!pend_wr_reg) begin
        data_next = pci_rdata;
      end
    end
    if (lb_valid) begin
      if (hit_addr) begin
        // Plain register, no PCI cycle
        ack_next = 1'b1;
        if (lb_req.write) begin
          addr_next = lb_req.wdata & pcig_pkg::CFG_ADDR_WMASK;
        end
        rdata_next = addr_reg;
      end else if ((hit_data || hit_vec) && !pci_master_enable) begin
        berr_next = 1'b1;
      end else if (hit_vec && lb_req.write) begin
        ack_next = 1'b1;
      end else if (hit_data || hit_vec) begin
        case (st_reg)
          pcig_pkg::PCIG_IDLE: begin
            // Launch and retry the master
            retry_next = 1'b1;
            st_next = pcig_pkg::PCIG_RUN;
            req_next = 1'b1;
            pend_off_next = lb_req.addr;
            pend_wr_next = lb_req.write;
            pend_wdat_next = lb_req.wdata;
            cyc_next.wdata = lb_req.wdata;
            if (hit_vec) begin
              cyc_next.cmd = pcig_pkg::PCI_CMD_IACK;
              cyc_next.addr = {20'h00000, lb_req.addr[11:2], lb_req.lsb};
              cyc_next.be_n = lanes_n(lb_req.size, lb_req.lsb);
            end else begin
              cyc_next.cmd = lb_req.write ? pcig_pkg::PCI_CMD_CFG_WR
                                          : pcig_pkg::PCI_CMD_CFG_RD;
              cyc_next.addr = cfg_ad(addr_reg);
              cyc_next.be_n = 4'h0;
            end
          end
          pcig_pkg::PCIG_RUN: begin
            retry_next = 1'b1;
          end
          default: begin
            // Completed: only the matching access takes the result
            if (lb_req.addr == pend_off_reg && lb_req.write == pend_wr_reg) begin
              ack_next = 1'b1;
              st_next = pcig_pkg::PCIG_IDLE;
              if (pend_wr_reg) begin
                data_next = pend_wdat_reg;
              end
              rdata_next = hit_vec ? vec_reg : data_reg;
            end else begin
              retry_next = 1'b1;
            end
          end
        endcase
      end else begin
        // Unmapped offsets read zero
        ack_next = 1'b1;
        rdata_next = 32'h00000000;
      end
    end
  end

  // Local channel registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_reg <= pcig_pkg::CFG_ADDR_RST;
      data_reg <= pcig_pkg::CFG_DATA_RST;
      vec_reg <= pcig_pkg::RETURNED_VECTOR_RST;
      st_reg <= pcig_pkg::PCIG_IDLE;
      pend_off_reg <= 12'h000;
      pend_wr_reg <= 1'b0;
      pend_wdat_reg <= 32'h00000000;
      req_reg <= 1'b0;
      cyc_reg <= '0;
      ack_reg <= 1'b0;
      retry_reg <= 1'b0;
      berr_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      addr_reg <= addr_next;
      data_reg <= data_next;
      vec_reg <= vec_next;
      st_reg <= st_next;
      pend_off_reg <= pend_off_next;
      pend_wr_reg <= pend_wr_next;
      pend_wdat_reg <= pend_wdat_next;
      req_reg <= req_next;
      cyc_reg <= cyc_next;
      ack_reg <= ack_next;
      retry_reg <= retry_next;
      berr_reg <= berr_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PCI side register access
  always_comb begin
    pack_next = pb_valid;
    prd_next = 32'h00000000;
    // Data and vector read zero, writes ignored
    if (pb_valid && !pb_write && pb_addr == pcig_pkg::CFG_ADDR_OFF) begin
      prd_next = addr_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pack_reg <= 1'b0;
      prd_reg <= 32'h00000000;
    end else begin
      pack_reg <= pack_next;
      prd_reg <= prd_next;
    end
  end

  assign lb_ack = ack_reg;
  assign lb_retry = retry_reg;
  assign lb_berr = berr_reg;
  assign lb_rdata = rdata_reg;
  assign pb_ack = pack_reg;
  assign pb_rdata = prd_reg;
  assign pci_req = req_reg;
  assign pci_cyc = cyc_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Launch checks look one edge after the taking edge, when the
  // registered cycle description first stands
  a_bit15_zero: assert property (@(posedge clk) disable iff (!rstn)
    addr_reg[15] == 1'b0) else $error("address bit 15 set");
  a_cfg_berr: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_data && !pci_master_enable |=> lb_berr && !lb_ack)
    else $error("no bus error on data register");
  a_vec_berr: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_vec && !pci_master_enable |=> lb_berr)
    else $error("no bus error on vector register");
  a_launch_retry: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_data && pci_master_enable && st_reg == pcig_pkg::PCIG_IDLE
    |=> lb_retry && pci_req) else $error("config not launched");
  a_pend_retry: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_data && pci_master_enable && st_reg == pcig_pkg::PCIG_RUN
    |=> lb_retry && !lb_ack)
    else $error("pending access not retried");
  a_done_drop: assert property (@(posedge clk) disable iff (!rstn)
    st_reg == pcig_pkg::PCIG_RUN && pci_done |=> !pci_req)
    else $error("request held after done");
  a_type0_onehot: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pci_req) && pci_cyc.cmd != pcig_pkg::PCI_CMD_IACK && !addr_reg[0]
    |-> $onehot(pci_cyc.addr[31:16]) && pci_cyc.addr[15:11] == 5'h00
    && pci_cyc.addr[1:0] == 2'h0) else $error("bad type 0 address");
  a_type0_fields: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pci_req) && pci_cyc.cmd != pcig_pkg::PCI_CMD_IACK && !addr_reg[0]
    |-> pci_cyc.addr[10:8] == addr_reg[pcig_pkg::CA_FUNC_LSB +: 3]
    && pci_cyc.addr[7:2] == addr_reg[pcig_pkg::CA_REG_LSB +: 6])
    else $error("bad type 0 fields");
  a_type1_addr: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pci_req) && pci_cyc.cmd != pcig_pkg::PCI_CMD_IACK && addr_reg[0]
    |-> pci_cyc.addr == addr_reg) else $error("bad type 1 address");
  a_cfg_wr_cmd: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_data && lb_req.write && pci_master_enable
    && st_reg == pcig_pkg::PCIG_IDLE
    |=> pci_cyc.cmd == pcig_pkg::PCI_CMD_CFG_WR) else $error("wrong write cmd");
  a_cfg_rd_cmd: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_data && !lb_req.write && pci_master_enable
    && st_reg == pcig_pkg::PCIG_IDLE
    |=> pci_cyc.cmd == pcig_pkg::PCI_CMD_CFG_RD) else $error("wrong read cmd");
  a_iack_cmd: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_vec && !lb_req.write && pci_master_enable
    && st_reg == pcig_pkg::PCIG_IDLE
    |=> pci_cyc.cmd == pcig_pkg::PCI_CMD_IACK
    && pci_cyc.addr[11:2] == $past(lb_req.addr[11:2])
    && pci_cyc.addr[1:0] == $past(lb_req.lsb))
    else $error("iack not launched");
  a_iack_lanes: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_vec && !lb_req.write && pci_master_enable
    && st_reg == pcig_pkg::PCIG_IDLE && lb_req.size == 2'b01
    |=> $countones(pci_cyc.be_n) == 3) else $error("byte lane wrong");
  a_vec_return: assert property (@(posedge clk) disable iff (!rstn)
    st_reg == pcig_pkg::PCIG_RUN && pci_done
    && pend_off_reg == pcig_pkg::RETURNED_VECTOR_OFF
    |=> vec_reg == $past(pci_rdata)) else $error("vector not latched");
  a_vec_readback: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_vec && !lb_req.write && pci_master_enable
    && st_reg == pcig_pkg::PCIG_DONE && pend_off_reg == pcig_pkg::RETURNED_VECTOR_OFF
    |=> lb_ack && lb_rdata == $past(vec_reg))
    else $error("vector not returned");
  a_pci_zero: assert property (@(posedge clk) disable iff (!rstn)
    pb_valid && pb_addr != pcig_pkg::CFG_ADDR_OFF |=> pb_rdata == 32'h00000000)
    else $error("pci side read not zero");
  a_pci_wr_none: assert property (@(posedge clk) disable iff (!rstn)
    pb_valid && pb_write && !lb_valid && st_reg != pcig_pkg::PCIG_RUN
    |=> $stable(data_reg) && $stable(addr_reg))
    else $error("pci side write had effect");
  a_vec_wr_none: assert property (@(posedge clk) disable iff (!rstn)
    lb_valid && hit_vec && lb_req.write && st_reg == pcig_pkg::PCIG_IDLE
    |=> !pci_req && $stable(vec_reg)) else $error("vector write had effect");
endmodule
`default_nettype wire

// >>> verification/pcig_pci_model.sv
`timescale 1ns/1ns
`default_nettype none
// PCI target and interrupt controller seen through the master engine
module pcig_pci_model (
  input wire logic clk,          // Clock
  input wire logic rstn,         // Reset, active low
  input wire logic pci_req,      // Cycle request level
  input wire logic [3:0] delay,  // Wait cycles before answering
  input wire logic [31:0] reply, // Data handed back
  output logic pci_done,         // Cycle finished pulse
  output logic [31:0] pci_rdata  // Returned data
);
  logic [3:0] cnt_reg; // Wait counter
  logic busy_reg;      // Answered, waiting for request drop
  ////////////////////////////////////////////////////////////////
  // Data is only valid with done; it toggles otherwise so a stale
  // capture cannot match by luck
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      pci_done <= 1'b0;
      pci_rdata <= 32'h0;
    end else begin
      pci_done <= 1'b0;
      pci_rdata <= ~pci_rdata;
      if (!pci_req) begin
        busy_reg <= 1'b0;
        cnt_reg <= 4'h0;
      end else if (!busy_reg && cnt_reg == delay) begin
        pci_done <= 1'b1;
        pci_rdata <= reply;
        busy_reg <= 1'b1;
      end else if (!busy_reg) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/pci_config_iack_generator_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pci_config_iack_generator_tb;
  localparam logic [2:0] ACK = 3'b100; // Answer codes: ack, retry, error
  localparam logic [2:0] RTY = 3'b010;
  localparam logic [2:0] BER = 3'b001;
  localparam logic [11:0] OA = pcig_pkg::CFG_ADDR_OFF;
  localparam logic [11:0] OD = pcig_pkg::CFG_DATA_OFF;
  localparam logic [11:0] OV = pcig_pkg::RETURNED_VECTOR_OFF;
  logic clk, rstn, lb_valid, lb_ack, lb_retry, lb_berr, pb_valid, pb_write, pb_ack;
  logic men, pci_req, pci_done;
  logic [11:0] pb_addr;
  logic [31:0] lb_rdata, pb_wdata, pb_rdata, pci_rdata, reply, rd;
  logic [3:0] dly;
  pcig_pkg::pcig_req_s req;
  pcig_pkg::pcig_pci_s cyc, cap;
  int mismatches, compares, n;
  pcig_regchan pcig_regchan_inst (.clk(clk), .rstn(rstn), .lb_valid(lb_valid),
    .lb_req(req), .lb_ack(lb_ack), .lb_retry(lb_retry), .lb_berr(lb_berr),
    .lb_rdata(lb_rdata), .pb_valid(pb_valid), .pb_addr(pb_addr), .pb_write(pb_write),
    .pb_wdata(pb_wdata), .pb_ack(pb_ack), .pb_rdata(pb_rdata),
    .pci_master_enable(men), .pci_req(pci_req), .pci_cyc(cyc),
    .pci_done(pci_done), .pci_rdata(pci_rdata));
  pcig_pci_model pcig_pci_model_inst (.clk(clk), .rstn(rstn), .pci_req(pci_req),
    .delay(dly), .reply(reply), .pci_done(pci_done), .pci_rdata(pci_rdata));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One local attempt; answer sampled mid-cycle after the taking edge
  task automatic lb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [1:0] sz, input logic [1:0] ls, input logic [2:0] k);
    @(posedge clk);
    lb_valid <= 1'b1;
    req <= '{addr: a, lsb: ls, size: sz, write: w, wdata: d};
    @(posedge clk);
    lb_valid <= 1'b0;
    @(negedge clk);
    chk("answer", {29'h0, k}, {29'h0, lb_ack, lb_retry, lb_berr});
    rd = lb_rdata;
  endtask
  task automatic pb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    pb_valid <= 1'b1;
    pb_addr <= a;
    pb_write <= w;
    pb_wdata <= d;
    @(posedge clk);
    pb_valid <= 1'b0;
    @(negedge clk);
    chk("pb ack", 32'h1, {31'h0, pb_ack});
    rd = pb_rdata;
  endtask
  // Bounded wait on the request level; a hang ends the run
  task automatic wait_req(input logic lvl);
    int i;
    for (i = 0; i < 40 && pci_req !== lvl; i++) @(negedge clk);
    if (pci_req !== lvl) begin
      mismatches++;
      tally_and_finish;
    end
  endtask
  // Delayed transfer: retry, PCI cycle, then the repeated access completes
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [1:0] sz, input logic [1:0] ls);
    lb(a, w, d, sz, ls, RTY);
    wait_req(1'b1);
    cap = cyc;
    if (dly > 4'h6) lb(a, w, d, sz, ls, RTY);
    wait_req(1'b0);
    lb(a, w, d, sz, ls, ACK);
  endtask
  function automatic logic [3:0] lanes_n(input logic [1:0] s, input logic [1:0] l);
    if (s == 2'b01) return ~(4'h1 << l);
    if (s == 2'b10) return l[1] ? 4'h3 : 4'hC;
    return 4'h0;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    lb_valid = 1'b0;
    req = '0;
    pb_valid = 1'b0;
    pb_addr = 12'h0;
    pb_write = 1'b0;
    pb_wdata = 32'h0;
    men = 1'b0;
    dly = 4'h0;
    reply = 32'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    lb(OA, 1'b0, 32'h0, 2'b00, 2'b00, ACK);
    chk("addr reset", pcig_pkg::CFG_ADDR_RST, rd);
    lb(OD, 1'b0, 32'h0, 2'b00, 2'b00, BER);
    lb(OV, 1'b0, 32'h0, 2'b00, 2'b00, BER);
    chk("no cycle", 32'h0, {31'h0, pci_req});
    @(posedge clk) men <= 1'b1;
    lb(OA, 1'b1, 32'hFFFFFFFF, 2'b00, 2'b00, ACK);
    lb(OA, 1'b0, 32'h0, 2'b00, 2'b00, ACK);
    chk("addr mask", 32'h00FF7FFD, rd);
    // Every device number, answer delay from prompt to slow
    for (n = 0; n < 16; n++) begin
      dly <= n[3:0];
      reply <= 32'h80C3A501 + n;
      lb(OA, 1'b1, {16'h0, 1'b0, n[3:0], 3'h5, 6'h2A, 2'b00}, 2'b00, 2'b00, ACK);
      xfer(OD, 1'b0, 32'h0, 2'b00, 2'b00);
      chk("t0 cmd", {28'h0, pcig_pkg::PCI_CMD_CFG_RD}, {28'h0, cap.cmd});
      chk("t0 ad", (32'h1 << (16 + n)) | 32'h5A8, cap.addr);
      chk("cfg read", 32'h80C3A501 + n, rd);
    end
    lb(OA, 1'b1, 32'h00AB3AF5, 2'b00, 2'b00, ACK);
    xfer(OD, 1'b1, 32'hA5C30F1E, 2'b00, 2'b00);
    chk("t1 cmd", {28'h0, pcig_pkg::PCI_CMD_CFG_WR}, {28'h0, cap.cmd});
    chk("t1 ad", 32'h00AB3AF5, cap.addr);
    chk("t1 data", 32'hA5C30F1E, cap.wdata);
    // Every size and low address pair on the vector read
    for (n = 0; n < 16; n++) begin
      dly <= 4'hF - n[3:0];
      reply <= 32'hF00D0000 | n;
      xfer(OV, 1'b0, 32'h0, n[3:2], n[1:0]);
      chk("ia cmd", {28'h0, pcig_pkg::PCI_CMD_IACK}, {28'h0, cap.cmd});
      chk("ia ad", {20'h0, 10'h142, n[1:0]}, cap.addr);
      chk("ia lanes", {28'h0, lanes_n(n[3:2], n[1:0])}, {28'h0, cap.be_n});
      chk("vector", 32'hF00D0000 | n, rd);
    end
    // A different access while a read result is unclaimed is retried
    lb(OD, 1'b0, 32'h0, 2'b00, 2'b00, RTY);
    wait_req(1'b0);
    lb(OV, 1'b0, 32'h0, 2'b00, 2'b00, RTY);
    lb(OD, 1'b0, 32'h0, 2'b00, 2'b00, ACK);
    chk("late read", 32'hF00D000F, rd);
    pb(OD, 1'b1, 32'hFFFFFFFF);
    pb(OV, 1'b1, 32'hFFFFFFFF);
    pb(OD, 1'b0, 32'h0);
    chk("pb data", 32'h0, rd);
    pb(OV, 1'b0, 32'h0);
    chk("pb vector", 32'h0, rd);
    pb(OA, 1'b0, 32'h0);
    chk("pb addr", 32'h00AB3AF5, rd);
    lb(OV, 1'b1, 32'h12345678, 2'b00, 2'b00, ACK);
    chk("no cycle", 32'h0, {31'h0, pci_req});
    lb(12'h50C, 1'b0, 32'h0, 2'b00, 2'b00, ACK);
    chk("unmapped", 32'h0, rd);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
